// ---- rtl/gcr_pkg.sv ----
// package: offsets, field positions, reset values and encodings of the global control bank
package gcr_pkg;

    // ------------------------------------------------------------------
    // register offsets (byte addresses on the processor port)
    // ------------------------------------------------------------------
    localparam int          ADDR_W                = 12;
    localparam logic [11:0] OFS_DEVICE_IDENTITY   = 12'h000;
    localparam logic [11:0] OFS_GLOBAL_CONTROL_1  = 12'h002;
    localparam logic [11:0] OFS_GLOBAL_CONTROL_2  = 12'h004;

    // ------------------------------------------------------------------
    // identity field positions and test-port word slices
    // ------------------------------------------------------------------
    localparam int ID_REV_MSB   = 31;              // revision in test-port word
    localparam int ID_REV_LSB   = 28;
    localparam int ID_CODE_MSB  = 23;              // part code slice
    localparam int ID_CODE_LSB  = 12;

    // ------------------------------------------------------------------
    // global control one bit positions
    // ------------------------------------------------------------------
    localparam int CR1_IRQ_IDLE_MODE    = 14;
    localparam int CR1_MANUAL_ERR_INS   = 7;
    localparam int CR1_ERR_SRC_SELECT   = 6;
    localparam int CR1_PERF_MODE_MSB    = 5;
    localparam int CR1_PERF_MODE_LSB    = 4;
    localparam int CR1_PERF_TRIGGER     = 3;
    localparam int CR1_CLEAR_ON_READ    = 2;
    localparam int CR1_DATAPATH_RESET   = 1;
    localparam int CR1_FULL_RESET       = 0;
    localparam logic [15:0] CR1_USED_MASK  = 16'h40ff;
    localparam logic [15:0] CR1_RESET_VAL  = 16'h0002;

    // ------------------------------------------------------------------
    // global control two bit positions
    // ------------------------------------------------------------------
    localparam int CR2_REF_SRC_MSB      = 11;
    localparam int CR2_REF_SRC_LSB      = 10;
    localparam int CR2_REF_OUT_SELECT   = 9;
    localparam int CR2_REF_PIN_SELECT   = 8;
    localparam int CR2_ADAPTER_MSB      = 3;
    localparam int CR2_ADAPTER_LSB      = 1;
    localparam logic [15:0] CR2_USED_MASK  = 16'h0f0e;
    localparam logic [15:0] CR2_RESET_VAL  = 16'h0000;

    // ------------------------------------------------------------------
    // timing: one second from the 8 kHz reference
    // ------------------------------------------------------------------
    localparam int REF_EDGES_PER_SECOND = 8000;

    // ------------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PERF_BY_SOFTWARE = 2'b00,
        PERF_BY_PIN      = 2'b01,
        PERF_BY_SECOND   = 2'b10,
        PERF_BY_SECOND_B = 2'b11
    } gcr_perf_mode_type;

    typedef enum logic [1:0] {
        REF_DISABLED   = 2'b00,
        REF_FROM_CLOCK = 2'b01,
        REF_FROM_PORT  = 2'b10,
        REF_UNDEFINED  = 2'b11
    } gcr_ref_src_type;

    typedef enum logic [2:0] {
        ADAPTER_44M736 = 3'b000,
        ADAPTER_34M368 = 3'b001,
        ADAPTER_51M84  = 3'b010,
        ADAPTER_19M44  = 3'b011,
        ADAPTER_77M76  = 3'b100
    } gcr_adapter_ref_type;

    // general pin two modes
    localparam logic [1:0] PIN_MODE_INPUT  = 2'b00;
    localparam logic [1:0] PIN_MODE_STATUS = 2'b01;
    localparam logic [1:0] PIN_MODE_LOW    = 2'b10;
    localparam logic [1:0] PIN_MODE_HIGH   = 2'b11;

endpackage

// ---- rtl/gcr_ref_if.sv ----
// interface: reference routing signals between control bank and reference router
`timescale 1ns/1ps
interface gcr_ref_if;
    import gcr_pkg::*;

    logic            hold;                 // datapath reset active
    gcr_ref_src_type ref_source_select;
    logic            ref_pin_input_select;
    logic            ref_output_select;
    logic [1:0]      general_pin_two_select;
    logic            ref_8k_global;
    logic            ref_8k_input;
    logic            one_sec_tick;

    // control bank side
    modport ctl (
        output hold, ref_source_select, ref_pin_input_select, ref_output_select,
        output general_pin_two_select,
        input  ref_8k_global, ref_8k_input, one_sec_tick
    );

    // router side
    modport route (
        input  hold, ref_source_select, ref_pin_input_select, ref_output_select,
        input  general_pin_two_select,
        output ref_8k_global, ref_8k_input, one_sec_tick
    );
endinterface

// ---- rtl/gcr_ref_route.sv ----
// reference router: 8 kHz source choice, pin routing and one-second timer
`timescale 1ns/1ps
module gcr_ref_route (
    // clock and reset
    input  wire logic CLK,
    input  wire logic RST,
    // link to control bank
    gcr_ref_if.route  rif,
    // reference sources
    input  wire logic clock_rate_adapter_ref_8k,
    input  wire logic port_ref_8k,
    input  wire logic pin_four_in,
    input  wire logic port_b_status,
    // general pin two drive
    output logic      pin_two_o,
    output logic      pin_two_oe_n
);
    import gcr_pkg::*;

    logic        ref_prev_r;
    logic [12:0] sec_cnt_r;
    logic        tick_r;
    logic        ref_rise;

    // internal reference input, low unless pin four is chosen
    assign rif.ref_8k_input = rif.ref_pin_input_select & pin_four_in;

    // global reference source selection
    always_comb begin
        if (rif.ref_pin_input_select) begin
            rif.ref_8k_global = rif.ref_8k_input;
        end else begin
            case (rif.ref_source_select)
                REF_FROM_CLOCK: rif.ref_8k_global = clock_rate_adapter_ref_8k;
                REF_FROM_PORT:  rif.ref_8k_global = port_ref_8k;
                default:        rif.ref_8k_global = 1'b0;
            endcase
        end
    end

    // general pin two: reference output or its own mode
    always_comb begin
        pin_two_o    = 1'b0;
        pin_two_oe_n = 1'b0;
        if (rif.ref_output_select) begin
            pin_two_o = rif.ref_8k_global;
        end else begin
            case (rif.general_pin_two_select)
                PIN_MODE_STATUS: pin_two_o = port_b_status;
                PIN_MODE_LOW:    pin_two_o = 1'b0;
                PIN_MODE_HIGH:   pin_two_o = 1'b1;
                default:         pin_two_oe_n = 1'b1;
            endcase
        end
    end

    assign ref_rise         = rif.ref_8k_global & ~ref_prev_r;
    assign rif.one_sec_tick = tick_r;

    // edge history of the global reference
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ref_prev_r <= 1'b0;
        end else begin
            ref_prev_r <= rif.ref_8k_global;
        end
    end

    // one-second counter from 8 kHz edges, cleared by datapath reset
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            sec_cnt_r <= 13'h0000;
            tick_r    <= 1'b0;
        end else if (rif.hold) begin
            sec_cnt_r <= 13'h0000;
            tick_r    <= 1'b0;
        end else begin
            tick_r <= 1'b0;
            if (ref_rise) begin
                if (sec_cnt_r == 13'(REF_EDGES_PER_SECOND - 1)) begin
                    sec_cnt_r <= 13'h0000;
                    tick_r    <= 1'b1;
                end else begin
                    sec_cnt_r <= sec_cnt_r + 13'h0001;
                end
            end
        end
    end
endmodule

// ---- rtl/gcr_top.sv ----
// global identity and control register bank with reference routing
`timescale 1ns/1ps

module gcr_top #(
    parameter logic [31:0] TEST_PORT_ID = 32'h1234_5678 // arbitrary neutral value
) (
    // clock and reset
    input  wire logic                   CLK,
    input  wire logic                   RST,
    // processor port
    input  wire logic                   CS,
    input  wire logic                   WR,
    input  wire logic                   RD,
    input  wire logic [gcr_pkg::ADDR_W-1:0] ADDR,
    input  wire logic [15:0]            WDATA,
    output logic      [15:0]            RDATA,
    output logic                        RDATA_VALID,
    // interrupt pin
    input  wire logic                   IRQ_ACTIVE,
    output logic                        IRQ_N_O,
    output logic                        IRQ_N_OE_N,
    // error insertion
    input  wire logic                   GENERAL_PIN_SIX,
    output logic                        ERROR_INSERT_PULSE,
    // performance monitor update
    input  wire logic                   GENERAL_PIN_EIGHT,
    input  wire logic                   PERF_CAPTURED,
    output logic                        PERF_UPDATE_PULSE,
    output logic                        PERF_UPDATE_DONE,
    // status and reset controls
    output logic                        LATCHED_CLEAR_ON_READ,
    output logic                        DATAPATH_RESET,
    output logic                        FULL_RESET,
    // references and pins
    input  wire logic                   CLOCK_RATE_ADAPTER_REF_8K,
    input  wire logic                   PORT_REF_8K,
    input  wire logic                   GENERAL_PIN_FOUR,
    input  wire logic                   PORT_B_STATUS,
    input  wire logic [1:0]             GENERAL_PIN_TWO_SELECT,
    output logic                        GENERAL_PIN_TWO_O,
    output logic                        GENERAL_PIN_TWO_OE_N,
    output logic                        REF_8K_GLOBAL,
    output logic                        REF_8K_INPUT,
    output logic                        ONE_SEC_TICK,
    output gcr_pkg::gcr_adapter_ref_type RATE_ADAPTER_REF_SELECT
);
    import gcr_pkg::*;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    gcr_ref_if   rif ();

    logic [15:0] ctrl_one_r;
    logic [15:0] ctrl_one_nxt;
    logic [15:0] ctrl_two_r;
    logic [15:0] ctrl_two_nxt;
    logic [15:0] identity;
    logic [15:0] rd_mux;
    logic        wr_one;
    logic        wr_two;
    logic        full_rst;
    logic        insert_prev_r;
    logic        pin_six_prev_r;
    logic        trig_prev_r;
    logic        pin_eight_prev_r;
    logic        insert_pulse_r;
    logic        update_pulse_r;
    logic        done_r;
    logic        trig_rise;
    logic        trig_fall;
    logic        update_event;
    logic        insert_event;
    gcr_perf_mode_type perf_mode;

    // ------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------

    // identity word mirrors the test-port identity
    assign identity = {TEST_PORT_ID[ID_REV_MSB:ID_REV_LSB],
                       TEST_PORT_ID[ID_CODE_MSB:ID_CODE_LSB]};

    assign wr_one   = CS & WR & (ADDR == OFS_GLOBAL_CONTROL_1);
    assign wr_two   = CS & WR & (ADDR == OFS_GLOBAL_CONTROL_2);
    assign full_rst = ctrl_one_r[CR1_FULL_RESET];

    // next value of control one; full reset forces all but its own bit
    always_comb begin
        ctrl_one_nxt = ctrl_one_r;
        if (wr_one) begin
            ctrl_one_nxt = WDATA & CR1_USED_MASK;
        end
        if (full_rst) begin
            ctrl_one_nxt = (CR1_RESET_VAL & ~(16'h0001 << CR1_FULL_RESET))
                         | (ctrl_one_nxt & (16'h0001 << CR1_FULL_RESET));
        end
    end

    // next value of control two; full reset forces defaults
    always_comb begin
        ctrl_two_nxt = ctrl_two_r;
        if (wr_two) begin
            ctrl_two_nxt = WDATA & CR2_USED_MASK;
        end
        if (full_rst) begin
            ctrl_two_nxt = CR2_RESET_VAL;
        end
    end

    // control register storage
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctrl_one_r <= CR1_RESET_VAL;
            ctrl_two_r <= CR2_RESET_VAL;
        end else begin
            ctrl_one_r <= ctrl_one_nxt;
            ctrl_two_r <= ctrl_two_nxt;
        end
    end

    // read data mux, unmapped addresses read zero
    always_comb begin
        case (ADDR)
            OFS_DEVICE_IDENTITY:  rd_mux = identity;
            OFS_GLOBAL_CONTROL_1: rd_mux = ctrl_one_r & CR1_USED_MASK;
            OFS_GLOBAL_CONTROL_2: rd_mux = ctrl_two_r & CR2_USED_MASK;
            default:              rd_mux = 16'h0000;
        endcase
    end

    // registered read answer, one cycle after the strobe
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            RDATA       <= 16'h0000;
            RDATA_VALID <= 1'b0;
        end else begin
            RDATA_VALID <= CS & RD;
            if (CS & RD) begin
                RDATA <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------------
    // interrupt pin
    // ------------------------------------------------------------------

    // active low drive; idle state releases or drives high
    always_comb begin
        if (IRQ_ACTIVE) begin
            IRQ_N_O    = 1'b0;
            IRQ_N_OE_N = 1'b0;
        end else begin
            IRQ_N_O    = 1'b1;
            IRQ_N_OE_N = ~ctrl_one_r[CR1_IRQ_IDLE_MODE];
        end
    end

    // ------------------------------------------------------------------
    // manual error insertion
    // ------------------------------------------------------------------

    // edge history of insertion sources
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            insert_prev_r  <= 1'b0;
            pin_six_prev_r <= 1'b0;
        end else begin
            insert_prev_r  <= ctrl_one_r[CR1_MANUAL_ERR_INS];
            pin_six_prev_r <= GENERAL_PIN_SIX;
        end
    end

    // rising edge of the selected source
    always_comb begin
        if (ctrl_one_r[CR1_ERR_SRC_SELECT]) begin
            insert_event = GENERAL_PIN_SIX & ~pin_six_prev_r;
        end else begin
            insert_event = ctrl_one_r[CR1_MANUAL_ERR_INS] & ~insert_prev_r;
        end
    end

    // one-cycle insertion request to the ports
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            insert_pulse_r <= 1'b0;
        end else begin
            insert_pulse_r <= insert_event & ~DATAPATH_RESET;
        end
    end

    assign ERROR_INSERT_PULSE = insert_pulse_r;

    // ------------------------------------------------------------------
    // performance monitor update
    // ------------------------------------------------------------------

    assign perf_mode = gcr_perf_mode_type'(ctrl_one_r[CR1_PERF_MODE_MSB:CR1_PERF_MODE_LSB]);
    assign trig_rise = ctrl_one_r[CR1_PERF_TRIGGER] & ~trig_prev_r;
    assign trig_fall = ~ctrl_one_r[CR1_PERF_TRIGGER] & trig_prev_r;

    // edge history of update sources
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            trig_prev_r      <= 1'b0;
            pin_eight_prev_r <= 1'b0;
        end else begin
            trig_prev_r      <= ctrl_one_r[CR1_PERF_TRIGGER];
            pin_eight_prev_r <= GENERAL_PIN_EIGHT;
        end
    end

    // update trigger selected by mode
    always_comb begin
        case (perf_mode)
            PERF_BY_SOFTWARE: update_event = trig_rise;
            PERF_BY_PIN:      update_event = GENERAL_PIN_EIGHT & ~pin_eight_prev_r;
            default:          update_event = rif.one_sec_tick;
        endcase
    end

    // capture-and-reset request to the counters
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            update_pulse_r <= 1'b0;
        end else begin
            update_pulse_r <= update_event & ~DATAPATH_RESET;
        end
    end

    // done flag: set by capture, cleared on trigger bit fall, set wins
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            done_r <= 1'b0;
        end else if (full_rst) begin
            done_r <= 1'b0;
        end else if (PERF_CAPTURED) begin
            done_r <= 1'b1;
        end else if (trig_fall) begin
            done_r <= 1'b0;
        end
    end

    assign PERF_UPDATE_PULSE = update_pulse_r;
    assign PERF_UPDATE_DONE  = done_r;

    // ------------------------------------------------------------------
    // status policy and resets
    // ------------------------------------------------------------------

    // clear policy and reset levels to the rest of the device
    assign LATCHED_CLEAR_ON_READ = ctrl_one_r[CR1_CLEAR_ON_READ];
    assign DATAPATH_RESET = ctrl_one_r[CR1_DATAPATH_RESET] | full_rst;
    assign FULL_RESET     = full_rst;

    // ------------------------------------------------------------------
    // references and adapter selection
    // ------------------------------------------------------------------

    // control fields to the reference router
    assign rif.hold                   = DATAPATH_RESET;
    assign rif.ref_source_select      =
        gcr_ref_src_type'(ctrl_two_r[CR2_REF_SRC_MSB:CR2_REF_SRC_LSB]);
    assign rif.ref_pin_input_select   = ctrl_two_r[CR2_REF_PIN_SELECT];
    assign rif.ref_output_select      = ctrl_two_r[CR2_REF_OUT_SELECT];
    assign rif.general_pin_two_select = GENERAL_PIN_TWO_SELECT;

    // reference router instance
    gcr_ref_route u_route (
        .CLK           (CLK),
        .RST           (RST),
        .rif           (rif),
        .clock_rate_adapter_ref_8k   (CLOCK_RATE_ADAPTER_REF_8K),
        .port_ref_8k   (PORT_REF_8K),
        .pin_four_in   (GENERAL_PIN_FOUR),
        .port_b_status (PORT_B_STATUS),
        .pin_two_o     (GENERAL_PIN_TWO_O),
        .pin_two_oe_n  (GENERAL_PIN_TWO_OE_N)
    );

    // reference observation outputs
    assign REF_8K_GLOBAL = rif.ref_8k_global;
    assign REF_8K_INPUT  = rif.ref_8k_input;
    assign ONE_SEC_TICK  = rif.one_sec_tick;

    // rate adapter reference frequency code
    assign RATE_ADAPTER_REF_SELECT =
        gcr_adapter_ref_type'(ctrl_two_r[CR2_ADAPTER_MSB:CR2_ADAPTER_LSB]);

endmodule

// ---- bench/gcr_checker.sv ----
// checker of the global control bank
`timescale 1ns/1ps
module gcr_checker
    import gcr_pkg::*;
(
    // clock, reset and processor port
    input wire logic                CLK, RST, CS, WR,
    input wire logic [ADDR_W-1:0]   ADDR,
    input wire logic [15:0]         WDATA,
    // pins and events
    input wire logic                IRQ_ACTIVE, IRQ_N_O, IRQ_N_OE_N, GENERAL_PIN_SIX,
    input wire logic                ERROR_INSERT_PULSE, PERF_CAPTURED, PERF_UPDATE_PULSE,
    input wire logic                PERF_UPDATE_DONE, LATCHED_CLEAR_ON_READ, DATAPATH_RESET,
    input wire logic                FULL_RESET, ONE_SEC_TICK,
    // references
    input wire logic                CLOCK_RATE_ADAPTER_REF_8K, PORT_REF_8K, GENERAL_PIN_FOUR,
    input wire logic [1:0]          GENERAL_PIN_TWO_SELECT,
    input wire logic                GENERAL_PIN_TWO_O, GENERAL_PIN_TWO_OE_N,
    input wire logic                REF_8K_GLOBAL, REF_8K_INPUT,
    input gcr_adapter_ref_type      RATE_ADAPTER_REF_SELECT
);
    // ------------------------------------------------------------------
    // shadow copies of both control registers
    // ------------------------------------------------------------------
    logic [15:0] s1_r;
    logic [15:0] s2_r;
    logic        wr1;
    logic        wr2;
    assign wr1 = CS && WR && ADDR == OFS_GLOBAL_CONTROL_1;
    assign wr2 = CS && WR && ADDR == OFS_GLOBAL_CONTROL_2;

    // full reset forces defaults, only bit 0 stays writable
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s1_r <= CR1_RESET_VAL;
            s2_r <= CR2_RESET_VAL;
        end else if (s1_r[0]) begin
            s1_r <= CR1_RESET_VAL | {15'h0, wr1 ? WDATA[0] : 1'b1};
            s2_r <= CR2_RESET_VAL;
        end else begin
            if (wr1) s1_r <= WDATA & CR1_USED_MASK;
            if (wr2) s2_r <= WDATA & CR2_USED_MASK;
        end
    end

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    property p_irq;
        IRQ_ACTIVE ? (!IRQ_N_O && !IRQ_N_OE_N) : (IRQ_N_O && IRQ_N_OE_N == !s1_r[14]);
    endproperty
    a_irq: assert property (p_irq)
        else $error("irq pin");
    property p_ins;
        $rose(s1_r[7]) && !s1_r[6] && !DATAPATH_RESET |=> ERROR_INSERT_PULSE;
    endproperty
    a_ins: assert property (p_ins)
        else $error("no insert pulse");
    property p_pin6;
        $rose(GENERAL_PIN_SIX) && s1_r[6] && !DATAPATH_RESET |=> ERROR_INSERT_PULSE;
    endproperty
    a_pin6: assert property (p_pin6)
        else $error("no pin six insert");
    property p_upd;
        $rose(s1_r[3]) && s1_r[5:4] == 2'b00 && !DATAPATH_RESET |=> PERF_UPDATE_PULSE;
    endproperty
    a_upd: assert property (p_upd)
        else $error("no update pulse");
    property p_done;
        $fell(s1_r[3]) && !PERF_CAPTURED ##1 !PERF_CAPTURED |-> !PERF_UPDATE_DONE;
    endproperty
    a_done: assert property (p_done)
        else $error("done not cleared");
    property p_hold;
        DATAPATH_RESET [*3] |-> !ERROR_INSERT_PULSE && !PERF_UPDATE_PULSE && !ONE_SEC_TICK;
    endproperty
    a_hold: assert property (p_hold)
        else $error("event in hold");
    property p_full;
        FULL_RESET |=> DATAPATH_RESET && !LATCHED_CLEAR_ON_READ
            && RATE_ADAPTER_REF_SELECT == ADAPTER_44M736;
    endproperty
    a_full: assert property (p_full)
        else $error("full reset default");
    property p_src;
        REF_8K_GLOBAL == (s2_r[8] ? GENERAL_PIN_FOUR : s2_r[11:10] == 2'b01 ? CLOCK_RATE_ADAPTER_REF_8K
            : s2_r[11:10] == 2'b10 ? PORT_REF_8K : 1'b0);
    endproperty
    a_src: assert property (p_src)
        else $error("ref source");
    property p_pin4;
        REF_8K_INPUT == (s2_r[8] & GENERAL_PIN_FOUR);
    endproperty
    a_pin4: assert property (p_pin4)
        else $error("ref input");
    property p_out;
        s2_r[9] ? (GENERAL_PIN_TWO_O == REF_8K_GLOBAL && !GENERAL_PIN_TWO_OE_N)
            : (GENERAL_PIN_TWO_OE_N == (GENERAL_PIN_TWO_SELECT == PIN_MODE_INPUT));
    endproperty
    a_out: assert property (p_out)
        else $error("pin two");
    property p_clock_rate_adapter;
        RATE_ADAPTER_REF_SELECT == s2_r[3:1];
    endproperty
    a_clock_rate_adapter: assert property (p_clock_rate_adapter)
        else $error("adapter");
endmodule

bind gcr_top gcr_checker u_chk (.*);

// ---- bench/test_gcr_top.sv ----
// testbench of the global control bank
`timescale 1ns/1ps
module test_gcr_top;
    import gcr_pkg::*;
    localparam logic [31:0] TPID = 32'h9abc_def1; // arbitrary value
    logic clk, rst, cs, wr, rd, irq, pin6, pin8, capt, clock_rate_adapter, pref, pin4, pb;
    logic rvalid, ioo, ioe, einp, upd, done, lcr, dpr, fr, p2o, p2oe, rg, ri, tick;
    logic [1:0]  sel2;
    logic [11:0] addr;
    logic [15:0] wdata, rdata, d, e2, q;
    gcr_adapter_ref_type ars;
    int fails, cmp_count, cyc, ne, nu, nt;

    gcr_top #(.TEST_PORT_ID(TPID)) DUT (.CLK(clk), .RST(rst), .CS(cs), .WR(wr), .RD(rd),
        .ADDR(addr), .WDATA(wdata), .RDATA(rdata), .RDATA_VALID(rvalid), .IRQ_ACTIVE(irq),
        .IRQ_N_O(ioo), .IRQ_N_OE_N(ioe), .GENERAL_PIN_SIX(pin6), .ERROR_INSERT_PULSE(einp),
        .GENERAL_PIN_EIGHT(pin8), .PERF_CAPTURED(capt), .PERF_UPDATE_PULSE(upd),
        .PERF_UPDATE_DONE(done), .LATCHED_CLEAR_ON_READ(lcr), .DATAPATH_RESET(dpr),
        .FULL_RESET(fr), .CLOCK_RATE_ADAPTER_REF_8K(clock_rate_adapter), .PORT_REF_8K(pref), .GENERAL_PIN_FOUR(pin4),
        .PORT_B_STATUS(pb), .GENERAL_PIN_TWO_SELECT(sel2), .GENERAL_PIN_TWO_O(p2o),
        .GENERAL_PIN_TWO_OE_N(p2oe), .REF_8K_GLOBAL(rg), .REF_8K_INPUT(ri),
        .ONE_SEC_TICK(tick), .RATE_ADAPTER_REF_SELECT(ars));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("unexpected at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task automatic wreg(input logic [11:0] a, input logic [15:0] v);
        @(posedge clk);
        {cs, wr, addr, wdata} <= {2'b11, a, v};
        @(posedge clk);
        {cs, wr, wdata} <= {2'b00, ~v};
    endtask
    task automatic rreg(input logic [11:0] a, output logic [15:0] v);
        @(posedge clk);
        {cs, rd, addr} <= {2'b11, a};
        @(posedge clk);
        {cs, rd} <= 2'b00;
        @(negedge clk);
        chk(rvalid, 1'b1);
        v = rdata;
    endtask
    task automatic clr();
        @(negedge clk);
        {ne, nu, nt} = '0;
    endtask
    task automatic tally_and_finish();
        if (fails == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // clock, event counters and hang guard
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        ne += int'(einp);
        nu += int'(upd);
        nt += int'(tick);
        if (cyc == 40000) begin
            fails++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        {rst, cs, wr, rd, irq, pin6, pin8, capt, clock_rate_adapter, pref, pin4, pb, sel2} = 14'h2000;
        {addr, wdata, fails, cmp_count, cyc, ne, nu, nt} = '0;
        void'($urandom(28569));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rreg(OFS_DEVICE_IDENTITY, q);
        chk(q, {TPID[31:28], TPID[23:12]});
        rreg(OFS_GLOBAL_CONTROL_1, q);
        chk(q, CR1_RESET_VAL);
        rreg(12'h006, q);
        chk(q, 16'h0000);
        // random register traffic with random pin levels
        for (int i = 0; i < 15; i++) begin
            d = 16'($urandom) & 16'hfffe;
            e2 = (16'($urandom) & 16'hfff1) | 16'((i % 5) << 1);
            @(posedge clk);
            {irq, pin4, pb, pref, clock_rate_adapter, sel2} <= 7'($urandom);
            wreg(OFS_GLOBAL_CONTROL_1, d);
            wreg(OFS_GLOBAL_CONTROL_2, e2);
            wreg(OFS_DEVICE_IDENTITY, e2);
            rreg(OFS_GLOBAL_CONTROL_1, q);
            chk(q, d & CR1_USED_MASK);
            chk(lcr, d[2]);
            chk(dpr, d[1]);
            chk(ioe, irq ? 1'b0 : !d[14]);
            chk(ioo, !irq);
            rreg(OFS_GLOBAL_CONTROL_2, q);
            chk(q, e2 & CR2_USED_MASK);
            chk(ars, 16'(i % 5));
            chk(ri, e2[8] & pin4);
            rreg(OFS_DEVICE_IDENTITY, q);
            chk(q, {TPID[31:28], TPID[23:12]});
        end
        // error insertion by bit, then by pin six
        wreg(OFS_GLOBAL_CONTROL_1, 16'h0000);
        clr();
        wreg(OFS_GLOBAL_CONTROL_1, 16'h0080);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk(ne, 1);
        clr();
        wreg(OFS_GLOBAL_CONTROL_1, 16'h0040);
        wreg(OFS_GLOBAL_CONTROL_1, 16'h00c0);
        @(posedge clk);
        pin6 <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk(ne, 1);
        // software update with done handshake
        clr();
        wreg(OFS_GLOBAL_CONTROL_1, 16'h0008);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk(nu, 1);
        @(posedge clk);
        capt <= 1'b1;
        @(posedge clk);
        capt <= 1'b0;
        @(negedge clk);
        chk(done, 1'b1);
        wreg(OFS_GLOBAL_CONTROL_1, 16'h0010);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(done, 1'b0);
        // pin eight mode ignores the update bit
        clr();
        wreg(OFS_GLOBAL_CONTROL_1, 16'h0018);
        @(posedge clk);
        pin8 <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk(nu, 1);
        // one second from a fast adapter reference
        wreg(OFS_GLOBAL_CONTROL_1, 16'h0002);
        wreg(OFS_GLOBAL_CONTROL_2, 16'h0400);
        wreg(OFS_GLOBAL_CONTROL_1, 16'h0020);
        clr();
        repeat (16000) @(posedge clk) clock_rate_adapter <= ~clock_rate_adapter;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk(nt, 1);
        chk(nu, 1);
        // full reset forces defaults but keeps itself
        wreg(OFS_GLOBAL_CONTROL_2, 16'h000e);
        wreg(OFS_GLOBAL_CONTROL_1, 16'h0005);
        rreg(OFS_GLOBAL_CONTROL_1, q);
        chk(q, 16'h0003);
        chk(fr, 1'b1);
        rreg(OFS_GLOBAL_CONTROL_2, q);
        chk(q, 16'h0000);
        wreg(OFS_GLOBAL_CONTROL_1, 16'h0000);
        rreg(OFS_GLOBAL_CONTROL_1, q);
        chk(q, CR1_RESET_VAL);
        tally_and_finish();
    end
endmodule
